// *** verilog/bscfe_consts.vh ***
// constants for the bulk storage command front end
`ifndef BSCFE_CONSTS_VH
`define BSCFE_CONSTS_VH
`define BSCFE_EP_IN_ADDR 8'h81
`define BSCFE_EP_OUT_ADDR 8'h01
`define BSCFE_EP_ATTR_BULK 8'h02
`define BSCFE_EP_MAX_PKT 8'h40
`define BSCFE_EP_INTERVAL 8'h00
`define BSCFE_INTF_SUBCLASS 8'h06
`define BSCFE_INTF_NUM_EPS 8'h02
`define BSCFE_PKT_MASK 6'h3F
`define BSCFE_CBW_BYTES 5'h1F
`define BSCFE_CSW_BYTES 5'h0D
`define BSCFE_CBW_SIG 32'h43425355
`define BSCFE_CSW_SIG 32'h53425355
`define BSCFE_BLK_SHIFT 9
`define BSCFE_OP_TUR 8'h00
`define BSCFE_OP_SENSE 8'h03
`define BSCFE_OP_INQ 8'h12
`define BSCFE_OP_MODE 8'h1A
`define BSCFE_OP_STARTSTOP 8'h1B
`define BSCFE_OP_LOCK 8'h1E
`define BSCFE_OP_FMTCAP 8'h23
`define BSCFE_OP_CAP 8'h25
`define BSCFE_OP_READ 8'h28
`define BSCFE_OP_WRITE 8'h2A
`define BSCFE_OP_VERIFY 8'h2F
`define BSCFE_LEN_INQ 32'h00000024
`define BSCFE_LEN_CAP 32'h00000008
`define BSCFE_LEN_FMT 32'h0000000C
`define BSCFE_LEN_MODE 32'h00000004
`define BSCFE_LEN_SENSE 32'h00000012
`define BSCFE_ST_PASS 8'h00
`define BSCFE_ST_FAIL 8'h01
`define BSCFE_KEY_NONE 4'h0
`define BSCFE_KEY_NOT_READY 4'h2
`define BSCFE_KEY_ILLEGAL 4'h5
`define BSCFE_ASC_NONE 8'h00
`define BSCFE_ASC_NO_MEDIUM 8'h3A
`define BSCFE_ASC_BAD_OP 8'h20
`endif

// *** verilog/bscfe_cmd_decode.v ***
// opcode decoder for the disk command block
`timescale 1ns/100ps
`include "bscfe_consts.vh"
module bscfe_cmd_decode
(
  input wire [7:0] opcode,
  output reg known,
  output reg dir_in,
  output reg is_read,
  output reg is_write,
  output reg [31:0] fixed_len
);
  always @*
  begin
    known = 1'b1;
    dir_in = 1'b1;
    is_read = 1'b0;
    is_write = 1'b0;
    fixed_len = 32'h00000000;
    case (opcode)
      `BSCFE_OP_INQ: fixed_len = `BSCFE_LEN_INQ;
      `BSCFE_OP_CAP: fixed_len = `BSCFE_LEN_CAP;
      `BSCFE_OP_FMTCAP: fixed_len = `BSCFE_LEN_FMT;
      `BSCFE_OP_READ: is_read = 1'b1;
      `BSCFE_OP_WRITE:
      begin
        is_write = 1'b1;
        dir_in = 1'b0;
      end
      `BSCFE_OP_MODE: fixed_len = `BSCFE_LEN_MODE;
      `BSCFE_OP_SENSE: fixed_len = `BSCFE_LEN_SENSE;
      `BSCFE_OP_LOCK: dir_in = 1'b0;
      `BSCFE_OP_TUR: dir_in = 1'b0;
      `BSCFE_OP_VERIFY: dir_in = 1'b0;
      `BSCFE_OP_STARTSTOP: dir_in = 1'b0;
      default: known = 1'b0;
    endcase
  end
endmodule // bscfe_cmd_decode

// *** verilog/bscfe_front_end.v ***
// bulk-only mass storage command front end, device side
`timescale 1ns/100ps
`include "bscfe_consts.vh"
module bscfe_front_end
#(
  parameter CAP_BLOCKS = 32'h00010000
)
(
  input wire ref_clk,
  input wire rst_n,
  input wire out_valid,
  input wire [7:0] out_data,
  output reg out_ready,
  output reg in_valid,
  output reg [7:0] in_data,
  output reg in_last,
  input wire in_ready,
  output reg [7:0] ep_in_addr,
  output reg [7:0] ep_out_addr,
  output reg [7:0] ep_attr,
  output reg [7:0] ep_max_pkt,
  output reg [7:0] ep_interval,
  output reg [7:0] intf_subclass,
  output reg [7:0] intf_num_eps,
  output reg [31:0] med_lba,
  output reg [15:0] med_blocks,
  output reg med_start,
  output reg med_dir_wr,
  output reg med_verify,
  input wire med_rd_valid,
  input wire [7:0] med_rd_data,
  output reg med_rd_ready,
  output reg med_wr_valid,
  output reg [7:0] med_wr_data,
  input wire med_wr_ready,
  input wire med_present_pin,
  output reg med_lock,
  output reg med_run
);
  localparam S_CBW = 3'h0;
  localparam S_DEC = 3'h1;
  localparam S_DIN = 3'h2;
  localparam S_DOUT = 3'h3;
  localparam S_CSW = 3'h4;

  reg [2:0] st_q, st_d;
  reg [4:0] idx_q, idx_d;
  reg [247:0] cbw_q, cbw_d;
  reg [31:0] cnt_q, cnt_d;
  reg [31:0] len_q, len_d;
  reg [7:0] status_q, status_d;
  reg [3:0] key_q, key_d;
  reg [7:0] asc_q, asc_d;
  reg out_ready_d, in_valid_d, in_last_d, rd_ready_d, wr_valid_d;
  reg [7:0] in_data_d, wr_data_d;
  reg lock_d, run_d, start_d, dir_wr_d, verify_d;
  reg [31:0] lba_d;
  reg [15:0] blocks_d;
  reg [2:0] pres_sync_q;
  reg present_q;
  wire known, dir_in, is_read, is_write;
  wire [31:0] fixed_len;
  wire [31:0] xlen;
  wire [31:0] tag;
  wire [7:0] opcode;
  wire [31:0] cmd_lba;
  wire [15:0] cmd_blocks;
  wire [31:0] xfer_len;
  wire [31:0] plan_len;
  wire [31:0] residue;
  wire take_out, take_rd;

  // little-endian wrapper fields; command block is big-endian inside
  assign tag = cbw_q[63:32];
  assign xlen = cbw_q[95:64];
  assign opcode = cbw_q[127:120];
  assign cmd_lba = {cbw_q[143:136], cbw_q[151:144], cbw_q[159:152],
    cbw_q[167:160]};
  assign cmd_blocks = {cbw_q[183:176], cbw_q[191:184]};
  assign xfer_len = (is_read | is_write) ?
    {7'h00, cmd_blocks, 9'h000} : fixed_len;
  // never move more than the host expects, nor against its direction
  assign plan_len = (cbw_q[103] != dir_in) ? 32'h00000000 :
    (xfer_len < xlen) ? xfer_len : xlen;
  assign residue = xlen - cnt_q;
  assign take_out = out_valid & out_ready;
  assign take_rd = med_rd_valid & med_rd_ready;

  bscfe_cmd_decode u_dec
  (
    .opcode(opcode),
    .known(known),
    .dir_in(dir_in),
    .is_read(is_read),
    .is_write(is_write),
    .fixed_len(fixed_len)
  );

  function [7:0] resp_byte;
    input [7:0] op;
    input [5:0] i;
    input [3:0] key;
    input [7:0] asc;
    reg [31:0] last;
    begin
      last = CAP_BLOCKS - 32'h00000001;
      resp_byte = 8'h00;
      case (op)
        `BSCFE_OP_SENSE:
          case (i)
            6'h00: resp_byte = 8'h70;
            6'h02: resp_byte = {4'h0, key};
            6'h07: resp_byte = 8'h0A;
            6'h0C: resp_byte = asc;
            default: resp_byte = 8'h00;
          endcase
        `BSCFE_OP_INQ:
          case (i)
            6'h01: resp_byte = 8'h80;
            6'h02: resp_byte = 8'h04;
            6'h03: resp_byte = 8'h02;
            6'h04: resp_byte = 8'h1F;
            default: resp_byte = 8'h00;
          endcase
        `BSCFE_OP_CAP:
          case (i)
            6'h00: resp_byte = last[31:24];
            6'h01: resp_byte = last[23:16];
            6'h02: resp_byte = last[15:8];
            6'h03: resp_byte = last[7:0];
            6'h06: resp_byte = 8'h02;
            default: resp_byte = 8'h00;
          endcase
        `BSCFE_OP_FMTCAP:
          case (i)
            6'h03: resp_byte = 8'h08;
            6'h04: resp_byte = CAP_BLOCKS[31:24];
            6'h05: resp_byte = CAP_BLOCKS[23:16];
            6'h06: resp_byte = CAP_BLOCKS[15:8];
            6'h07: resp_byte = CAP_BLOCKS[7:0];
            6'h08: resp_byte = 8'h02;
            6'h0A: resp_byte = 8'h02;
            default: resp_byte = 8'h00;
          endcase
        `BSCFE_OP_MODE:
          resp_byte = (i == 6'h00) ? 8'h03 : 8'h00;
        default: resp_byte = 8'h00;
      endcase
    end
  endfunction

  function [7:0] csw_byte;
    input [4:0] i;
    input [31:0] t;
    input [31:0] res;
    input [7:0] s;
    reg [103:0] w;
    begin
      w = {s, res, t, `BSCFE_CSW_SIG};
      csw_byte = w[i*8 +: 8];
    end
  endfunction

  always @*
  begin
    st_d = st_q;
    idx_d = idx_q;
    cbw_d = cbw_q;
    cnt_d = cnt_q;
    len_d = len_q;
    status_d = status_q;
    key_d = key_q;
    asc_d = asc_q;
    in_valid_d = in_valid;
    in_data_d = in_data;
    in_last_d = in_last;
    rd_ready_d = 1'b0;
    wr_valid_d = med_wr_valid;
    wr_data_d = med_wr_data;
    out_ready_d = 1'b0;
    lock_d = med_lock;
    run_d = med_run;
    start_d = 1'b0;
    dir_wr_d = med_dir_wr;
    verify_d = 1'b0;
    lba_d = med_lba;
    blocks_d = med_blocks;
    if (in_valid & in_ready)
      in_valid_d = 1'b0;
    if (med_wr_valid & med_wr_ready)
      wr_valid_d = 1'b0;
    case (st_q)
      S_CBW:
      begin
        out_ready_d = 1'b1;
        if (take_out)
        begin
          cbw_d[idx_q*8 +: 8] = out_data;
          idx_d = idx_q + 5'h01;
          if (idx_q == `BSCFE_CBW_BYTES - 5'h01)
          begin
            idx_d = 5'h00;
            out_ready_d = 1'b0;
            st_d = S_DEC;
          end
        end
      end
      S_DEC:
      begin
        // a wrapper with a bad signature is dropped without status
        if (cbw_q[31:0] != `BSCFE_CBW_SIG)
          st_d = S_CBW;
        else
        begin
          cnt_d = 32'h00000000;
          len_d = known ? plan_len : 32'h00000000;
          status_d = `BSCFE_ST_PASS;
          if (opcode != `BSCFE_OP_SENSE)
          begin
            key_d = `BSCFE_KEY_NONE;
            asc_d = `BSCFE_ASC_NONE;
          end
          if (!known)
          begin
            status_d = `BSCFE_ST_FAIL;
            key_d = `BSCFE_KEY_ILLEGAL;
            asc_d = `BSCFE_ASC_BAD_OP;
          end
          else if (!present_q && (opcode == `BSCFE_OP_TUR || is_read
            || is_write || opcode == `BSCFE_OP_VERIFY))
          begin
            status_d = `BSCFE_ST_FAIL;
            key_d = `BSCFE_KEY_NOT_READY;
            asc_d = `BSCFE_ASC_NO_MEDIUM;
            len_d = 32'h00000000;
          end
          else
          begin
            // control bit is bit 0 of command byte 4, wrapper byte 19
            if (opcode == `BSCFE_OP_LOCK)
              lock_d = cbw_q[152];
            if (opcode == `BSCFE_OP_STARTSTOP)
              run_d = cbw_q[152];
            if (is_read | is_write | (opcode == `BSCFE_OP_VERIFY))
            begin
              start_d = 1'b1;
              dir_wr_d = is_write;
              verify_d = (opcode == `BSCFE_OP_VERIFY);
              lba_d = cmd_lba;
              blocks_d = cmd_blocks;
            end
          end
          st_d = dir_in ? S_DIN : S_DOUT;
        end
      end
      S_DIN:
      begin
        if (cnt_q == len_q)
        begin
          if (!in_valid_d)
            st_d = S_CSW;
        end
        else if (is_read)
        begin
          rd_ready_d = !in_valid_d && !take_rd;
          if (take_rd)
          begin
            in_valid_d = 1'b1;
            in_data_d = med_rd_data;
            cnt_d = cnt_q + 32'h00000001;
          end
        end
        else if (!in_valid_d)
        begin
          in_valid_d = 1'b1;
          in_data_d = resp_byte(opcode, cnt_q[5:0], key_q, asc_q);
          cnt_d = cnt_q + 32'h00000001;
          if (opcode == `BSCFE_OP_SENSE && cnt_d == len_q)
          begin
            key_d = `BSCFE_KEY_NONE;
            asc_d = `BSCFE_ASC_NONE;
          end
        end
        // full packet ends on a 64-byte boundary, short packet on the last byte of len_q
        if (cnt_d != cnt_q)
          in_last_d = (cnt_d[5:0] == 6'h00) || (cnt_d == len_q);
      end
      S_DOUT:
      begin
        if (cnt_q == len_q)
        begin
          if (!wr_valid_d)
            st_d = S_CSW;
        end
        else
        begin
          // one byte in flight keeps the ready a plain flop
          out_ready_d = !wr_valid_d && !take_out;
          if (take_out)
          begin
            wr_valid_d = 1'b1;
            wr_data_d = out_data;
            cnt_d = cnt_q + 32'h00000001;
          end
        end
      end
      S_CSW:
      begin
        if (!in_valid_d)
        begin
          if (idx_q == `BSCFE_CSW_BYTES)
          begin
            idx_d = 5'h00;
            st_d = S_CBW;
          end
          else
          begin
            in_valid_d = 1'b1;
            in_data_d = csw_byte(idx_q, tag, residue, status_q);
            in_last_d = (idx_q == `BSCFE_CSW_BYTES - 5'h01);
            idx_d = idx_q + 5'h01;
          end
        end
      end
      default: st_d = S_CBW;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_q <= S_CBW;
      idx_q <= 5'h00;
      cbw_q <= 248'h0;
      cnt_q <= 32'h00000000;
      len_q <= 32'h00000000;
      status_q <= `BSCFE_ST_PASS;
      key_q <= `BSCFE_KEY_NONE;
      asc_q <= `BSCFE_ASC_NONE;
      out_ready <= 1'b0;
      in_valid <= 1'b0;
      in_data <= 8'h00;
      in_last <= 1'b0;
      med_rd_ready <= 1'b0;
      med_wr_valid <= 1'b0;
      med_wr_data <= 8'h00;
      med_lock <= 1'b0;
      med_run <= 1'b1;
      med_start <= 1'b0;
      med_dir_wr <= 1'b0;
      med_verify <= 1'b0;
      med_lba <= 32'h00000000;
      med_blocks <= 16'h0000;
      pres_sync_q <= 3'h0;
      present_q <= 1'b0;
      ep_in_addr <= `BSCFE_EP_IN_ADDR;
      ep_out_addr <= `BSCFE_EP_OUT_ADDR;
      ep_attr <= `BSCFE_EP_ATTR_BULK;
      ep_max_pkt <= `BSCFE_EP_MAX_PKT;
      ep_interval <= `BSCFE_EP_INTERVAL;
      intf_subclass <= `BSCFE_INTF_SUBCLASS;
      intf_num_eps <= `BSCFE_INTF_NUM_EPS;
    end
    else
    begin
      st_q <= st_d;
      idx_q <= idx_d;
      cbw_q <= cbw_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      status_q <= status_d;
      key_q <= key_d;
      asc_q <= asc_d;
      out_ready <= out_ready_d;
      in_valid <= in_valid_d;
      in_data <= in_data_d;
      in_last <= in_last_d;
      med_rd_ready <= rd_ready_d;
      med_wr_valid <= wr_valid_d;
      med_wr_data <= wr_data_d;
      med_lock <= lock_d;
      med_run <= run_d;
      med_start <= start_d;
      med_dir_wr <= dir_wr_d;
      med_verify <= verify_d;
      med_lba <= lba_d;
      med_blocks <= blocks_d;
      pres_sync_q <= {pres_sync_q[1:0], med_present_pin};
      // card-detect pin: change taken once stages two and three agree
      if (pres_sync_q[1] == pres_sync_q[2])
        present_q <= pres_sync_q[2];
    end
  end
endmodule // bscfe_front_end

// *** tb/bscfe_monitor.sv ***
// port checker for the bulk storage front end
`timescale 1ns/100ps
module bscfe_monitor
(
  input wire ref_clk,
  input wire rst_n,
  input wire in_valid,
  input wire [7:0] in_data,
  input wire in_last,
  input wire in_ready,
  input wire [7:0] ep_in_addr,
  input wire [7:0] ep_out_addr,
  input wire [7:0] ep_attr,
  input wire [7:0] ep_max_pkt,
  input wire [7:0] ep_interval,
  input wire [7:0] intf_subclass,
  input wire [7:0] intf_num_eps,
  input wire med_start,
  input wire med_verify
);
  // bytes taken since the last packet end
  reg [5:0] pkt_q;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  always @(posedge ref_clk)
    if (!rst_n || (in_valid && in_ready && in_last))
      pkt_q <= 6'h00;
    else if (in_valid && in_ready)
      pkt_q <= pkt_q + 6'h01;
  AST_EP_ADDR: assert property ({ep_in_addr, ep_out_addr} == 16'h8101)
    else $error("endpoint address wrong");
  AST_EP_ATTR: assert property (ep_attr == 8'h02)
    else $error("endpoint attributes wrong");
  AST_EP_PKT: assert property (ep_max_pkt == 8'h40)
    else $error("max packet wrong");
  AST_EP_POLL: assert property (ep_interval == 8'h00)
    else $error("interval wrong");
  AST_SUBCLASS: assert property (intf_subclass == 8'h06)
    else $error("subclass wrong");
  AST_NUM_EPS: assert property (intf_num_eps == 8'h02)
    else $error("endpoint count wrong");
  AST_IN_HOLD: assert property (in_valid && !in_ready |=>
    in_valid && $stable(in_data) && $stable(in_last))
    else $error("in byte changed before taken");
  AST_PKT_END: assert property (in_valid && pkt_q == 6'h3F |-> in_last)
    else $error("packet longer than 64 bytes");
  AST_VERIFY: assert property (med_verify |-> med_start)
    else $error("verify without start");
  AST_START: assert property (med_start |=> !med_start)
    else $error("start not a pulse");
  cover property (in_valid && in_ready && in_last);
  cover property (in_valid && pkt_q == 6'h3F);
  cover property (med_verify);
endmodule // bscfe_monitor

bind bscfe_front_end bscfe_monitor MON (.ref_clk, .rst_n, .in_valid,
  .in_data, .in_last, .in_ready, .ep_in_addr, .ep_out_addr, .ep_attr,
  .ep_max_pkt, .ep_interval, .intf_subclass, .intf_num_eps, .med_start,
  .med_verify);

// *** tb/bscfe_host_model.sv ***
// host side of the two bulk streams
`timescale 1ns/100ps
module bscfe_host_model
(
  input wire ref_clk,
  output reg out_valid,
  output reg [7:0] out_data,
  input wire out_ready,
  input wire in_valid,
  input wire [7:0] in_data,
  input wire in_last,
  output reg in_ready
);
  integer stall;
  initial
  begin
    out_valid = 1'b0;
    out_data = 8'h00;
    in_ready = 1'b0;
    stall = 0;
  end
  // valid stays high between bytes so wrappers go back to back
  task put(input [7:0] b);
    integer n;
    begin
      out_valid = 1'b1;
      out_data = b;
      n = 0;
      while (!out_ready && n < 400)
      begin
        @(negedge ref_clk);
        n = n + 1;
      end
      @(negedge ref_clk);
    end
  endtask
  task idle;
    begin
      out_valid = 1'b0;
      out_data = ~out_data;
    end
  endtask
  task get(output [7:0] b, output l);
    integer n;
    begin
      n = 0;
      @(negedge ref_clk);
      while (!in_valid && n < 4000)
      begin
        @(negedge ref_clk);
        n = n + 1;
      end
      repeat (stall) @(negedge ref_clk);
      in_ready = 1'b1;
      b = in_data;
      l = in_last;
      @(negedge ref_clk);
      in_ready = 1'b0;
    end
  endtask
endmodule // bscfe_host_model

// *** tb/bscfe_front_end_bench.sv ***
// self-checking bench for the bulk storage front end
`timescale 1ns/100ps
module bscfe_front_end_bench;
  reg ref_clk, rst_n, med_rd_valid, med_wr_ready, med_present_pin;
  reg [7:0] med_rd_data;
  reg [7:0] d [0:17];
  wire out_valid, out_ready, in_valid, in_last, in_ready, med_start;
  wire [7:0] out_data, in_data, ep_in_addr, ep_out_addr, ep_attr;
  wire [7:0] ep_max_pkt, ep_interval, intf_subclass, intf_num_eps;
  wire [7:0] med_wr_data;
  wire [31:0] med_lba;
  wire [15:0] med_blocks;
  wire med_dir_wr, med_verify, med_rd_ready, med_wr_valid, med_lock, med_run;
  integer failures, n_compared, cycles, rd_cnt, wr_cnt, wr_bad, k, seed;
  reg [31:0] lba;
  bscfe_front_end DUT (.ref_clk, .rst_n, .out_valid, .out_data, .out_ready,
    .in_valid, .in_data, .in_last, .in_ready, .ep_in_addr, .ep_out_addr,
    .ep_attr, .ep_max_pkt, .ep_interval, .intf_subclass, .intf_num_eps,
    .med_lba, .med_blocks, .med_start, .med_dir_wr, .med_verify,
    .med_rd_valid, .med_rd_data, .med_rd_ready, .med_wr_valid, .med_wr_data,
    .med_wr_ready, .med_present_pin, .med_lock, .med_run);
  bscfe_host_model host (.ref_clk, .out_valid, .out_data, .out_ready,
    .in_valid, .in_data, .in_last, .in_ready);
  function [7:0] rd_pat(input integer i);
    rd_pat = i[7:0] ^ 8'h5A;
  endfunction
  function [31:0] plan(input [7:0] op, input [31:0] exp, input [15:0] blk);
    reg [31:0] f;
    begin
      case (op)
        8'h12: f = 32'h24;
        8'h25: f = 32'h08;
        8'h23: f = 32'h0C;
        8'h1A: f = 32'h04;
        8'h03: f = 32'h12;
        8'h28, 8'h2A: f = {blk, 9'h000};
        default: f = 32'h00;
      endcase
      plan = f < exp ? f : exp;
    end
  endfunction
  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task test_done;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task run(input [7:0] op, input [31:0] exp, input [7:0] b4,
    input [15:0] blk, input [7:0] st);
    reg [7:0] c [0:30];
    reg [31:0] tag, n, i;
    reg l;
    begin
      tag = $urandom;
      n = (st == 8'h00) ? plan(op, exp, blk) : 32'h0;
      rd_cnt = 0;
      wr_cnt = 0;
      wr_bad = 0;
      for (i = 0; i < 31; i = i + 1)
        c[i] = 8'h00;
      {c[3], c[2], c[1], c[0]} = 32'h43425355;
      {c[7], c[6], c[5], c[4], c[11], c[10], c[9], c[8]} = {tag, exp};
      c[12] = (op == 8'h2A) ? 8'h00 : 8'h80;
      {c[14], c[15], c[17], c[18], c[19], c[20]} = {8'h0A, op, lba};
      {c[22], c[23]} = blk;
      c[19] = c[19] | b4;
      for (i = 0; i < 31; i = i + 1)
        host.put(c[i]);
      // write data follows the wrapper with valid held high
      for (i = 0; i < n && op == 8'h2A; i = i + 1)
        host.put(i[7:0] ^ 8'hC3);
      host.idle;
      for (i = 0; i < n && op != 8'h2A; i = i + 1)
      begin
        host.get(c[0], l);
        check("pkt end", l, i == n - 1 || i[5:0] == 6'h3F);
        if (op == 8'h28)
          check("read data", c[0], rd_pat(i));
        if (i < 18)
          d[i] = c[0];
      end
      for (i = 0; i < 13; i = i + 1)
        host.get(c[i], l);
      check("status end", l, 1'b1);
      check("sig", {c[3], c[2], c[1], c[0]}, 32'h53425355);
      check("tag", {c[7], c[6], c[5], c[4]}, tag);
      check("residue", {c[11], c[10], c[9], c[8]}, exp - n);
      check("status", c[12], st);
      if (op == 8'h2A)
        check("written", wr_cnt - wr_bad * 256, n);
    end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // medium side: random handshakes, data inverted when not valid
  always @(negedge ref_clk)
  begin
    med_rd_valid = ($urandom % 3) != 0;
    med_rd_data = med_rd_valid ? rd_pat(rd_cnt) : ~rd_pat(rd_cnt);
    if (med_rd_valid && med_rd_ready)
      rd_cnt = rd_cnt + 1;
    med_wr_ready = ($urandom % 2) != 0;
    if (med_wr_ready && med_wr_valid)
    begin
      if (med_wr_data !== (wr_cnt[7:0] ^ 8'hC3))
        wr_bad = wr_bad + 1;
      wr_cnt = wr_cnt + 1;
    end
    cycles = cycles + 1;
    if (cycles > 60000)
    begin
      failures = failures + 1;
      test_done;
    end
  end
  initial
  begin
    rst_n = 1'b0;
    med_present_pin = 1'b1;
    {failures, n_compared, cycles, rd_cnt, wr_cnt, wr_bad} = 0;
    lba = 32'h0;
    seed = $urandom(42308);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) rst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    check("ep in", ep_in_addr, 8'h81);
    check("ep out", ep_out_addr, 8'h01);
    check("attr", ep_attr, 8'h02);
    check("max pkt", ep_max_pkt, 8'h40);
    check("interval", ep_interval, 8'h00);
    check("subclass", intf_subclass, 8'h06);
    check("num eps", intf_num_eps, 8'h02);
    for (k = 0; k < 5; k = k + 1)
      run(8'(40'h031A232512 >> (8 * k)), $urandom % 48, 0, 0,
        8'h00);
    run(8'h1E, 0, 8'h01, 0, 8'h00);
    check("lock", med_lock, 1'b1);
    run(8'h1E, 0, 8'h00, 0, 8'h00);
    check("unlock", med_lock, 1'b0);
    run(8'h1B, 0, 8'h00, 0, 8'h00);
    check("unloaded", med_run, 1'b0);
    run(8'h1B, 0, 8'h01, 0, 8'h00);
    check("loaded", med_run, 1'b1);
    run(8'h00, 0, 8'h00, 0, 8'h00);
    lba = $urandom & 32'h0000FFF0;
    run(8'h2F, 0, 8'h00, 1, 8'h00);
    check("verify lba", med_lba, lba);
    host.stall = 2;
    run(8'h28, 64 + $urandom % 100, 8'h00, 1, 8'h00);
    check("read blocks", {med_blocks, med_lba}, {16'h1, lba});
    check("read dir", med_dir_wr, 1'b0);
    host.stall = 0;
    run(8'h2A, 20 + $urandom % 60, 8'h00, 1, 8'h00);
    check("write dir", med_dir_wr, 1'b1);
    run(8'h55, 0, 8'h00, 0, 8'h01);
    run(8'h03, 18, 8'h00, 0, 8'h00);
    check("sense", {d[2][3:0], d[12]}, 12'h520);
    med_present_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
    run(8'h00, 0, 8'h00, 0, 8'h01);
    run(8'h03, 18, 8'h00, 0, 8'h00);
    check("no medium", {d[2][3:0], d[12]}, 12'h23A);
    test_done;
  end
endmodule // bscfe_front_end_bench
